// ### nav_host_model.sv
// Purpose: Host side that takes payload bytes from the formatter.
// Assumes: One byte is taken per cycle with outValid and outReady high.
// Notes: Slow mode takes a byte only every other cycle.
`timescale 1ns/1ps
`default_nettype none
module nav_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control from bench
  input wire logic slow,
  input wire logic clr,
  // Byte stream
  input wire logic outValid,
  input wire logic [7:0] outData,
  input wire logic outLast,
  output logic outReady,
  // Captured payload
  output logic [7:0] rxBuf [16],
  output logic [4:0] rxCnt,
  output logic gotLast
);
  logic tick;
  // Stall every other cycle in slow mode so held bytes get exercised
  assign outReady = !slow || tick;
  // Bytes are stored in arrival order, low byte of each field first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
      rxCnt <= 5'h00;
      gotLast <= 1'b0;
    end else if (clr) begin
      rxCnt <= 5'h00;
      gotLast <= 1'b0;
    end else begin
      tick <= !tick;
      if (outValid && outReady) begin
        rxBuf[rxCnt[3:0]] <= outData;
        rxCnt <= rxCnt + 5'h01;
        if (outLast) begin
          gotLast <= 1'b1;
        end
      end
    end
  end
endmodule // nav_host_model
`default_nettype wire

// ### nav_pkt_pkg.sv
// Purpose: Types shared by the formatter files.
// Assumes: Nothing beyond the constants header.
// Notes: Holds types only.
`default_nettype none
package nav_pkt_pkg;
  typedef enum logic [2:0] {KIND_EPOCH, KIND_CAL, KIND_STAT, KIND_POSDEV, KIND_VELDEV,
    KIND_ORIDEV} kind_e;
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND} state_e;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// ### nav_pkt_regs.svh
// Purpose: Named constants for the navigation state packet formatter.
// Assumes: Payload bytes are numbered from zero in transmit order.
// Notes: Definitions only.
`ifndef NAV_PKT_REGS_SVH
`define NAV_PKT_REGS_SVH
// Packet identifiers
`define ID_EPOCH 8'h15
`define ID_CAL 8'h16
`define ID_STAT 8'h17
`define ID_POSDEV 8'h18
`define ID_VELDEV 8'h19
`define ID_ORIDEV 8'h1A
// Payload lengths in bytes
`define LEN_EPOCH 8'h08
`define LEN_CAL 8'h0E
`define LEN_STAT 8'h04
`define LEN_DEV 8'h0C
// Field ranges
`define USEC_MAX 32'h000F423F
`define YDAY_MAX 16'h016D
`define MONTH_MAX 8'h0B
`define MDAY_MAX 8'h1F
`define WDAY_MAX 8'h06
`define HOUR_MAX 8'h17
`define MINSEC_MAX 8'h3B
// Payload store depth and selector width, and number of packet kinds
`define PAY_DEPTH 16
`define PAY_AW 4
`define NUM_KINDS 6
`endif

// ### nav_state_packet_formatter.sv
// Purpose: Builds payloads of six fixed-length navigation state packets as a byte stream.
// Assumes: Field values come from logic on clk_sys; framing and checksum lie downstream.
// Notes: Time fields except unixSeconds and year are out-of-range clamped; multi-byte fields go least significant byte first.
`timescale 1ns/1ps
`default_nettype none
`include "nav_pkt_regs.svh"
module nav_state_packet_formatter (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // Packet request
  input wire logic reqValid,
  input wire logic [2:0] reqKind,
  output logic reqReady,
  // Time fields
  input wire logic [31:0] unixSeconds,
  input wire logic [31:0] microSeconds,
  input wire logic [15:0] year,
  input wire logic [15:0] yearDay,
  input wire logic [7:0] month,
  input wire logic [7:0] monthDay,
  input wire logic [7:0] weekDay,
  input wire logic [7:0] hour,
  input wire logic [7:0] minute,
  input wire logic [7:0] second,
  // Status words
  input wire logic [15:0] systemStatus,
  input wire logic [15:0] filterStatus,
  // Deviation floats, three per packet
  input wire logic [31:0] posDev [3],
  input wire logic [31:0] velDev [3],
  input wire logic [31:0] oriDev [3],
  // Payload byte stream
  output logic pktStart,
  output logic [7:0] pktId,
  output logic [7:0] pktLen,
  output logic outValid,
  output logic [7:0] outData,
  output logic outLast,
  input wire logic outReady
);
  typedef struct packed {
    nav_pkt_pkg::state_e st;
    logic [`PAY_AW-1:0] cnt;
    logic [7:0] len;
    logic [7:0] id;
    logic start;
    logic vld;
  } fmt_s;

  fmt_s cur_r, cur_nxt;
  logic [7:0] image [`PAY_DEPTH];
  logic [`PAY_AW-1:0] rdAddr;
  logic [7:0] memData;
  logic wrEn;
  logic [7:0] snap_r [`PAY_DEPTH];
  logic [7:0] snapByte;

  // Clamp helper keeps each one-byte calendar field inside its documented range
  function automatic logic [7:0] lim8(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi);
    lim8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Byte image of the selected packet, low byte first
  always_comb begin
    logic [31:0] usec;
    logic [15:0] yday;
    usec = (microSeconds > `USEC_MAX) ? `USEC_MAX : microSeconds;
    yday = (yearDay > `YDAY_MAX) ? `YDAY_MAX : yearDay;
    for (int i = 0; i < `PAY_DEPTH; i++) begin
      image[i] = 8'h00;
    end
    case (nav_pkt_pkg::kind_e'(reqKind))
      nav_pkt_pkg::KIND_EPOCH: begin
        for (int b = 0; b < 4; b++) begin
          image[b] = unixSeconds[8*b +: 8];
          image[4+b] = usec[8*b +: 8];
        end
      end
      nav_pkt_pkg::KIND_CAL: begin
        for (int b = 0; b < 4; b++) begin
          image[b] = usec[8*b +: 8];
        end
        for (int b = 0; b < 2; b++) begin
          image[4+b] = year[8*b +: 8];
          image[6+b] = yday[8*b +: 8];
        end
        image[8] = lim8(month, 8'h00, `MONTH_MAX);
        image[9] = lim8(monthDay, 8'h01, `MDAY_MAX);
        image[10] = lim8(weekDay, 8'h00, `WDAY_MAX);
        image[11] = lim8(hour, 8'h00, `HOUR_MAX);
        image[12] = lim8(minute, 8'h00, `MINSEC_MAX);
        image[13] = lim8(second, 8'h00, `MINSEC_MAX);
      end
      nav_pkt_pkg::KIND_STAT: begin
        for (int b = 0; b < 2; b++) begin
          image[b] = systemStatus[8*b +: 8];
          image[2+b] = filterStatus[8*b +: 8];
        end
      end
      nav_pkt_pkg::KIND_POSDEV, nav_pkt_pkg::KIND_VELDEV, nav_pkt_pkg::KIND_ORIDEV: begin
        for (int f = 0; f < 3; f++) begin
          for (int b = 0; b < 4; b++) begin
            if (reqKind == 3'(nav_pkt_pkg::KIND_POSDEV)) begin
              image[4*f+b] = posDev[f][8*b +: 8];
            end else if (reqKind == 3'(nav_pkt_pkg::KIND_VELDEV)) begin
              image[4*f+b] = velDev[f][8*b +: 8];
            end else begin
              image[4*f+b] = oriDev[f][8*b +: 8];
            end
          end
        end
      end
      default: begin
        image[0] = 8'h00;
      end
    endcase
  end

  // Identifier and length per kind
  logic [7:0] kindId, kindLen;
  always_comb begin
    case (nav_pkt_pkg::kind_e'(reqKind))
      nav_pkt_pkg::KIND_EPOCH: begin kindId = `ID_EPOCH; kindLen = `LEN_EPOCH; end
      nav_pkt_pkg::KIND_CAL: begin kindId = `ID_CAL; kindLen = `LEN_CAL; end
      nav_pkt_pkg::KIND_STAT: begin kindId = `ID_STAT; kindLen = `LEN_STAT; end
      nav_pkt_pkg::KIND_POSDEV: begin kindId = `ID_POSDEV; kindLen = `LEN_DEV; end
      nav_pkt_pkg::KIND_VELDEV: begin kindId = `ID_VELDEV; kindLen = `LEN_DEV; end
      nav_pkt_pkg::KIND_ORIDEV: begin kindId = `ID_ORIDEV; kindLen = `LEN_DEV; end
      default: begin kindId = 8'h00; kindLen = 8'h00; end
    endcase
  end

  // Payload store: snapshot written in ST_LOAD, one byte per cycle
  assign wrEn = (cur_r.st == nav_pkt_pkg::ST_LOAD);
  pay_mem uMem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .wrEn(wrEn),
    .wrAddr(cur_r.cnt),
    .wrData(snapByte),
    .rdAddr(rdAddr),
    .rdData(memData)
  );

  // Snapshot of the image taken at acceptance so fields stay coherent
  assign snapByte = snap_r[cur_r.cnt];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `PAY_DEPTH; i++) begin
        snap_r[i] <= 8'h00;
      end
    end else if (clkEn && reqValid && reqReady) begin
      for (int i = 0; i < `PAY_DEPTH; i++) begin
        snap_r[i] <= image[i];
      end
    end
  end

  // Read address runs one ahead of the byte on the output when it advances, else stays on that byte
  logic advance;
  assign advance = cur_r.vld && outReady;
  assign rdAddr = advance ? cur_r.cnt + `PAY_AW'(1) : cur_r.cnt;

  // Sequencer
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.start = 1'b0;
    case (cur_r.st)
      nav_pkt_pkg::ST_IDLE: begin
        if (reqValid && kindLen != 8'h00) begin
          cur_nxt.st = nav_pkt_pkg::ST_LOAD;
          cur_nxt.cnt = '0;
          cur_nxt.id = kindId;
          cur_nxt.len = kindLen;
        end
      end
      nav_pkt_pkg::ST_LOAD: begin
        if (8'(cur_r.cnt) == cur_r.len - 8'h01) begin
          cur_nxt.st = nav_pkt_pkg::ST_SEND;
          cur_nxt.cnt = '0;
          cur_nxt.start = 1'b1;
        end else begin
          cur_nxt.cnt = cur_r.cnt + `PAY_AW'(1);
        end
      end
      nav_pkt_pkg::ST_SEND: begin
        if (!cur_r.vld) begin
          cur_nxt.vld = 1'b1; // Read data now valid for byte 0
        end else if (outReady) begin
          if (8'(cur_r.cnt) == cur_r.len - 8'h01) begin
            cur_nxt.vld = 1'b0;
            cur_nxt.st = nav_pkt_pkg::ST_IDLE;
          end else begin
            cur_nxt.cnt = cur_r.cnt + `PAY_AW'(1);
          end
        end
      end
      default: cur_nxt.st = nav_pkt_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_r <= '{st: nav_pkt_pkg::ST_IDLE, default: '0};
    end else if (clkEn) begin
      cur_r <= cur_nxt;
    end
  end

  // Outputs; handshake is combinational, data from flip-flops
  assign reqReady = (cur_r.st == nav_pkt_pkg::ST_IDLE);
  assign pktStart = cur_r.start;
  assign pktId = cur_r.id;
  assign pktLen = cur_r.len;
  assign outValid = cur_r.vld;
  assign outData = memData;
  assign outLast = cur_r.vld && (8'(cur_r.cnt) == cur_r.len - 8'h01);

  chk_epoch_id_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reqValid && reqReady && clkEn && reqKind == 3'h0) |=> (pktId == 8'h15 && pktLen == 8'h08))
    else $error("epoch id or length wrong");
  chk_cal_id_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reqValid && reqReady && clkEn && reqKind == 3'h1) |=> (pktId == 8'h16 && pktLen == 8'h0E))
    else $error("calendar id or length wrong");
  chk_stat_id_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reqValid && reqReady && clkEn && reqKind == 3'h2) |=> (pktId == 8'h17 && pktLen == 8'h04))
    else $error("status id or length wrong");
  chk_dev_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reqValid && reqReady && clkEn && reqKind > 3'h2 && reqKind < 3'h6) |=>
    (pktLen == 8'h0C && pktId == 8'h15 + 8'($past(reqKind))))
    else $error("deviation id or length wrong");
  chk_usec_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reqKind == 3'h0) |-> ({image[7], image[6], image[5], image[4]} <= 32'h000F423F))
    else $error("microseconds out of range");
  chk_month_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reqKind == 3'h1) |-> (image[8] <= 8'h0B && image[9] >= 8'h01 && image[9] <= 8'h1F))
    else $error("month fields out of range");
  chk_clock_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reqKind == 3'h1) |-> (image[10] <= 8'h06 && image[11] <= 8'h17 && image[13] <= 8'h3B))
    else $error("clock fields out of range");
  chk_status_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reqKind == 3'h2) |-> ({image[1], image[0]} == systemStatus && image[2] == filterStatus[7:0]))
    else $error("status bytes misplaced");
  chk_out_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (outValid && !outReady && clkEn) |=> (outValid && $stable(outData)))
    else $error("byte dropped under stall");
endmodule // nav_state_packet_formatter
`default_nettype wire

// ### pay_mem.sv
// Purpose: Small payload byte store with registered read data.
// Assumes: One write and one read port on clk_sys.
// Notes: Read data appear one enabled cycle after the address.
`timescale 1ns/1ps
`default_nettype none
`include "nav_pkt_regs.svh"
module pay_mem (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // Write side
  input wire logic wrEn,
  input wire logic [`PAY_AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  // Read side
  input wire logic [`PAY_AW-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [`PAY_DEPTH];
  // Storage has no reset; only the read register is cleared
  always_ff @(posedge clk_sys) begin
    if (clkEn && wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end
  // Registered read port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else if (clkEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule // pay_mem
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench for the navigation packet formatter.
// Assumes: Host model captures each payload in order.
// Notes: Inputs change on the falling edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys, rst_n, reqValid, reqReady, slow, clr, seen;
  logic clkEn;
  logic [2:0] reqKind;
  logic [31:0] unixSeconds, microSeconds;
  logic [15:0] year, yearDay, systemStatus, filterStatus;
  logic [7:0] month, monthDay, weekDay, hour, minute, second;
  logic [31:0] posDev [3], velDev [3], oriDev [3];
  logic pktStart, outValid, outLast, outReady, gotLast;
  logic [7:0] pktId, pktLen, outData;
  logic [7:0] rxBuf [16], want [16];
  logic [4:0] rxCnt;
  int nErrors, totalChecks, cyc;
  nav_state_packet_formatter dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
    .reqValid(reqValid), .reqKind(reqKind), .reqReady(reqReady),
    .unixSeconds(unixSeconds), .microSeconds(microSeconds), .year(year),
    .yearDay(yearDay), .month(month), .monthDay(monthDay), .weekDay(weekDay),
    .hour(hour), .minute(minute), .second(second), .systemStatus(systemStatus),
    .filterStatus(filterStatus), .posDev(posDev), .velDev(velDev), .oriDev(oriDev),
    .pktStart(pktStart), .pktId(pktId), .pktLen(pktLen), .outValid(outValid),
    .outData(outData), .outLast(outLast), .outReady(outReady));
  nav_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .clr(clr),
    .outValid(outValid), .outData(outData), .outLast(outLast), .outReady(outReady),
    .rxBuf(rxBuf), .rxCnt(rxCnt), .gotLast(gotLast));
  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      nErrors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (nErrors == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e) begin
      nErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Expected payload, least significant byte first
  task automatic put(input int off, input int n, input logic [31:0] v);
    for (int i = 0; i < n; i++) begin
      want[off+i] = v[8*i+:8];
    end
  endtask
  // One request, then wait for the whole payload and compare it
  task automatic send(input logic [2:0] k, input logic [7:0] id, input logic [7:0] len);
    int w;
    clr = 1'b1;
    @(negedge clk_sys);
    clr = 1'b0;
    reqKind = k;
    reqValid = 1'b1;
    chk(reqReady, 1'b1);
    @(negedge clk_sys);
    reqValid = 1'b0;
    w = 0;
    seen = 1'b0;
    while (gotLast !== 1'b1 && w < 300) begin
      @(negedge clk_sys);
      seen = seen | pktStart;
      w++;
    end
    chk(seen, 1'b1);
    chk(pktId, id);
    chk(pktLen, len);
    chk(rxCnt, len);
    for (int i = 0; i < len; i++) begin
      chk(rxBuf[i], want[i]);
    end
  endtask
  task automatic t_epoch();
    unixSeconds = 32'h5A0B1C2D;
    microSeconds = 32'h000F423F;
    put(0, 4, 32'h5A0B1C2D);
    put(4, 4, 32'h000F423F);
    slow = 1'b1;
    send(3'h0, 8'h15, 8'h08);
    slow = 1'b0;
  endtask
  // Upper bounds and zero microseconds must pass untouched
  task automatic t_cal_edge();
    microSeconds = 32'h00000000;
    {year, yearDay} = {16'h07DF, 16'h016D};
    {month, monthDay, weekDay} = {8'h0B, 8'h1F, 8'h06};
    {hour, minute, second} = {8'h17, 8'h3B, 8'h3B};
    put(0, 4, 32'h00000000);
    put(4, 4, 32'h016D07DF);
    put(8, 4, 32'h17061F0B);
    put(12, 2, 32'h00003B3B);
    send(3'h1, 8'h16, 8'h0E);
  endtask
  // Out-of-range inputs come out clamped to the field limits
  task automatic t_cal_clamp();
    microSeconds = 32'h000F4240;
    {year, yearDay} = {16'hFFFF, 16'h016E};
    {month, monthDay, weekDay} = {8'h0C, 8'h00, 8'h07};
    {hour, minute, second} = {8'h18, 8'h3C, 8'hFF};
    put(0, 4, 32'h000F423F);
    put(4, 4, 32'h016DFFFF);
    put(8, 4, 32'h1706010B);
    put(12, 2, 32'h00003B3B);
    send(3'h1, 8'h16, 8'h0E);
  endtask
  task automatic t_status();
    systemStatus = 16'hA5C3;
    filterStatus = 16'h5A3C;
    put(0, 4, 32'h5A3CA5C3);
    send(3'h2, 8'h17, 8'h04);
  endtask
  // All three deviation kinds, back to back
  task automatic t_dev();
    for (int j = 0; j < 3; j++) begin
      posDev[j] = 32'h3F800000 + j;
      velDev[j] = 32'h40A01100 + j;
      oriDev[j] = 32'h3C23D700 + j;
    end
    for (int k = 3; k < 6; k++) begin
      for (int j = 0; j < 3; j++) begin
        put(4*j, 4, k == 3 ? posDev[j] : k == 4 ? velDev[j] : oriDev[j]);
      end
      send(k[2:0], 8'h15 + k[7:0], 8'h0C);
    end
  endtask
  // Enable low freezes the sequencer; a request then must not be taken
  task automatic t_freeze();
    clkEn = 1'b0;
    reqKind = 3'h2;
    reqValid = 1'b1;
    seen = 1'b0;
    repeat (10) begin
      @(negedge clk_sys);
      seen = seen | pktStart | outValid;
    end
    chk(seen, 1'b0);
    chk(reqReady, 1'b1);
    reqValid = 1'b0;
    clkEn = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(pktId, 8'h1A);
  endtask
  // Unused kind codes must never start a packet
  task automatic t_refuse();
    reqValid = 1'b1;
    for (int k = 6; k < 8; k++) begin
      reqKind = k[2:0];
      seen = 1'b0;
      repeat (20) begin
        @(negedge clk_sys);
        seen = seen | pktStart;
      end
      chk(seen, 1'b0);
      chk(reqReady, 1'b1);
    end
    reqValid = 1'b0;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    {rst_n, reqValid, slow, clr, reqKind} = 7'h00;
    clkEn = 1'b1;
    {unixSeconds, microSeconds, year, yearDay} = 96'h0;
    {month, monthDay, weekDay, hour, minute, second} = 48'h0;
    {systemStatus, filterStatus} = 32'h0;
    for (int j = 0; j < 3; j++) begin
      {posDev[j], velDev[j], oriDev[j]} = 96'h0;
    end
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    t_epoch();
    t_cal_edge();
    t_cal_clamp();
    t_status();
    t_dev();
    t_freeze();
    t_refuse();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
